// [design/capture_compare_unit.v]
`timescale 1ns/10ps
`include "capture_compare_defs.vh"

module capture_compare_unit #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             CORE_CLK_I,
    input  wire             RST_I,
    // avalon-mm slave
    input  wire [3:0]       AVS_ADDRESS_I,
    input  wire             AVS_READ_I,
    input  wire             AVS_WRITE_I,
    input  wire [31:0]      AVS_WRITEDATA_I,
    input  wire [3:0]       AVS_BYTEENABLE_I,
    output reg  [31:0]      AVS_READDATA_O,
    output wire             AVS_WAITREQUEST_O,
    // timers
    input  wire [WIDTH-1:0] FIRST_TIMER_I,
    input  wire [WIDTH-1:0] THIRD_TIMER_I,
    output wire             FIRST_TIMER_CLEAR_O,
    output wire             THIRD_TIMER_CLEAR_O,
    // converter
    input  wire             CONVERTER_ENABLED_I,
    output wire             CONVERSION_START_O,
    // pins
    input  wire             UNIT1_PIN_I,
    input  wire             UNIT2_PIN_I,
    output wire             UNIT1_PIN_O,
    output wire             UNIT2_PIN_O,
    output wire             UNIT1_PIN_OWNED_O,
    output wire             UNIT2_PIN_OWNED_O,
    // event flags
    output wire             UNIT1_EVENT_FLAG_O,
    output wire             UNIT2_EVENT_FLAG_O
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function is_capture;
        input [3:0] m;
        begin
            is_capture = (m[3:2] == 2'b01);
        end
    endfunction

    function is_compare;
        input [3:0] m;
        begin
            is_compare = (m == `MODE_CMP_TOGGLE) || (m[3:2] == 2'b10);
        end
    endfunction

    function [7:0] byte_write;
        input [7:0] old;
        input [7:0] din;
        input       en;
        begin
            byte_write = en ? din : old;
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg  [5:0]       control1;
    reg  [5:0]       control2;
    reg  [WIDTH-1:0] value1;
    reg  [WIDTH-1:0] value2;
    reg  [1:0]       time_base_select;
    reg              flag1;
    reg              flag2;
    reg              out1;
    reg              out2;
    reg  [3:0]       presc1;
    reg  [3:0]       presc2;
    reg  [2:0]       sync1;
    reg  [2:0]       sync2;
    reg              cmp_hit1;
    reg              cmp_hit2;
    reg              read_pending;

    wire [3:0] mode1 = control1[3:0];
    wire [3:0] mode2 = control2[3:0];

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire wr_req = AVS_WRITE_I;
    wire lane0  = AVS_BYTEENABLE_I[0];

    // reads take one wait cycle so data comes from flops
    assign AVS_WAITREQUEST_O = AVS_READ_I && !read_pending;

    wire wr_ctrl1 = wr_req && lane0 && (AVS_ADDRESS_I == `ADDR_UNIT1_CONTROL);
    wire wr_low1  = wr_req && lane0 && (AVS_ADDRESS_I == `ADDR_UNIT1_VALUE_LOW);
    wire wr_high1 = wr_req && lane0 && (AVS_ADDRESS_I == `ADDR_UNIT1_VALUE_HIGH);
    wire wr_ctrl2 = wr_req && lane0 && (AVS_ADDRESS_I == `ADDR_UNIT2_CONTROL);
    wire wr_low2  = wr_req && lane0 && (AVS_ADDRESS_I == `ADDR_UNIT2_VALUE_LOW);
    wire wr_high2 = wr_req && lane0 && (AVS_ADDRESS_I == `ADDR_UNIT2_VALUE_HIGH);
    wire wr_sel   = wr_req && lane0 && (AVS_ADDRESS_I == `ADDR_TIME_BASE);
    wire wr_flags = wr_req && lane0 && (AVS_ADDRESS_I == `ADDR_FLAGS);

    // ----------------------------------------
    // time base selection
    // ----------------------------------------
    // select encoding
    wire unit1_third = time_base_select[1];
    wire unit2_third = time_base_select[1] | time_base_select[0];
    wire [WIDTH-1:0] base1 = unit1_third ? THIRD_TIMER_I : FIRST_TIMER_I;
    wire [WIDTH-1:0] base2 = unit2_third ? THIRD_TIMER_I : FIRST_TIMER_I;

    // ----------------------------------------
    // pin synchronisers and edges
    // ----------------------------------------
    // two flops before edge logic
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {sync1[1:0], UNIT1_PIN_I};
            sync2 <= {sync2[1:0], UNIT2_PIN_I};
        end
    end

    // pin level seen even when driven
    wire rise1 = sync1[1] & ~sync1[2];
    wire fall1 = ~sync1[1] & sync1[2];
    wire rise2 = sync2[1] & ~sync2[2];
    wire fall2 = ~sync2[1] & sync2[2];

    wire cap1 = is_capture(mode1) &&
                ((mode1 == `MODE_CAP_FALL   && fall1) ||
                 (mode1 == `MODE_CAP_RISE   && rise1) ||
                 (mode1 == `MODE_CAP_RISE4  && rise1 && presc1[1:0] == 2'h3) ||
                 (mode1 == `MODE_CAP_RISE16 && rise1 && presc1 == 4'hf));
    wire cap2 = is_capture(mode2) &&
                ((mode2 == `MODE_CAP_FALL   && fall2) ||
                 (mode2 == `MODE_CAP_RISE   && rise2) ||
                 (mode2 == `MODE_CAP_RISE4  && rise2 && presc2[1:0] == 2'h3) ||
                 (mode2 == `MODE_CAP_RISE16 && rise2 && presc2 == 4'hf));

    // ----------------------------------------
    // compare match
    // ----------------------------------------
    // one event per entry into equality
    wire eq1    = is_compare(mode1) && (value1 == base1);
    wire eq2    = is_compare(mode2) && (value2 == base2);
    wire match1 = eq1 && !cmp_hit1;
    wire match2 = eq2 && !cmp_hit2;

    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cmp_hit1 <= 1'b0;
            cmp_hit2 <= 1'b0;
        end else begin
            cmp_hit1 <= eq1;
            cmp_hit2 <= eq2;
        end
    end

    wire special1 = match1 && (mode1 == `MODE_CMP_SPECIAL);
    wire special2 = match2 && (mode2 == `MODE_CMP_SPECIAL);

    assign FIRST_TIMER_CLEAR_O = (special1 && !unit1_third) || (special2 && !unit2_third);
    assign THIRD_TIMER_CLEAR_O = (special1 && unit1_third) || (special2 && unit2_third);
    assign CONVERSION_START_O  = special2 && CONVERTER_ENABLED_I;

    // ----------------------------------------
    // prescaler counters
    // ----------------------------------------
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            presc1 <= 4'h0;
            presc2 <= 4'h0;
        end else begin
            // cleared when off or not capturing
            if (!is_capture(mode1) || wr_ctrl1 && !is_capture(AVS_WRITEDATA_I[3:0]))
                presc1 <= 4'h0;
            else if (rise1)
                presc1 <= presc1 + 4'h1;
            if (!is_capture(mode2) || wr_ctrl2 && !is_capture(AVS_WRITEDATA_I[3:0]))
                presc2 <= 4'h0;
            else if (rise2)
                presc2 <= presc2 + 4'h1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            control1         <= 6'h00;
            control2         <= 6'h00;
            value1           <= `VALUE_RESET;
            value2           <= `VALUE_RESET;
            time_base_select <= `SEL_RESET;
        end else begin
            if (wr_ctrl1)
                control1 <= AVS_WRITEDATA_I[5:0];
            if (wr_ctrl2)
                control2 <= AVS_WRITEDATA_I[5:0];
            if (wr_sel)
                time_base_select <= AVS_WRITEDATA_I[1:0];
            if (cap1)
                value1 <= base1;
            else
                value1 <= {byte_write(value1[15:8], AVS_WRITEDATA_I[7:0], wr_high1),
                           byte_write(value1[7:0], AVS_WRITEDATA_I[7:0], wr_low1)};
            if (cap2)
                value2 <= base2;
            else
                value2 <= {byte_write(value2[15:8], AVS_WRITEDATA_I[7:0], wr_high2),
                           byte_write(value2[7:0], AVS_WRITEDATA_I[7:0], wr_low2)};
        end
    end

    // ----------------------------------------
    // event flags
    // ----------------------------------------
    // only documented modes raise events
    wire act1 = cap1 || (match1 && mode1 != `MODE_OFF);
    wire act2 = cap2 || (match2 && mode2 != `MODE_OFF);

    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            flag1 <= 1'b0;
            flag2 <= 1'b0;
        end else begin
            if (act1)
                flag1 <= 1'b1;
            else if (wr_flags && AVS_WRITEDATA_I[0])
                flag1 <= 1'b0;
            if (act2)
                flag2 <= 1'b1;
            else if (wr_flags && AVS_WRITEDATA_I[1])
                flag2 <= 1'b0;
        end
    end

    assign UNIT1_EVENT_FLAG_O = flag1;
    assign UNIT2_EVENT_FLAG_O = flag2;

    // ----------------------------------------
    // compare output latches
    // ----------------------------------------
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            out1 <= 1'b0;
            out2 <= 1'b0;
        end else begin
            // control write of zero forces low
            if (wr_ctrl1 && AVS_WRITEDATA_I[3:0] == `MODE_OFF)
                out1 <= 1'b0;
            else if (wr_ctrl1 && AVS_WRITEDATA_I[3:0] == `MODE_CMP_SET_HIGH)
                out1 <= 1'b0;
            else if (wr_ctrl1 && AVS_WRITEDATA_I[3:0] == `MODE_CMP_SET_LOW)
                out1 <= 1'b1;
            else if (match1) begin
                case (mode1)
                    `MODE_CMP_TOGGLE:   out1 <= ~out1;
                    `MODE_CMP_SET_HIGH: out1 <= 1'b1;
                    `MODE_CMP_SET_LOW:  out1 <= 1'b0;
                    default:            out1 <= out1;
                endcase
            end
            if (wr_ctrl2 && AVS_WRITEDATA_I[3:0] == `MODE_OFF)
                out2 <= 1'b0;
            else if (wr_ctrl2 && AVS_WRITEDATA_I[3:0] == `MODE_CMP_SET_HIGH)
                out2 <= 1'b0;
            else if (wr_ctrl2 && AVS_WRITEDATA_I[3:0] == `MODE_CMP_SET_LOW)
                out2 <= 1'b1;
            else if (match2) begin
                case (mode2)
                    `MODE_CMP_TOGGLE:   out2 <= ~out2;
                    `MODE_CMP_SET_HIGH: out2 <= 1'b1;
                    `MODE_CMP_SET_LOW:  out2 <= 1'b0;
                    default:            out2 <= out2;
                endcase
            end
        end
    end

    // soft mode leaves pin to port
    assign UNIT1_PIN_O       = out1;
    assign UNIT2_PIN_O       = out2;
    assign UNIT1_PIN_OWNED_O = is_compare(mode1) && mode1 != `MODE_CMP_SOFT && mode1 != `MODE_CMP_SPECIAL;
    assign UNIT2_PIN_OWNED_O = is_compare(mode2) && mode2 != `MODE_CMP_SOFT && mode2 != `MODE_CMP_SPECIAL;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            read_pending   <= 1'b0;
            AVS_READDATA_O <= 32'h00000000;
        end else begin
            read_pending <= AVS_READ_I && !read_pending;
            if (AVS_READ_I && !read_pending) begin
                case (AVS_ADDRESS_I)
                    `ADDR_UNIT1_CONTROL:    AVS_READDATA_O <= {26'h0, control1};
                    `ADDR_UNIT1_VALUE_LOW:  AVS_READDATA_O <= {24'h0, value1[7:0]};
                    `ADDR_UNIT1_VALUE_HIGH: AVS_READDATA_O <= {24'h0, value1[15:8]};
                    `ADDR_UNIT2_CONTROL:    AVS_READDATA_O <= {26'h0, control2};
                    `ADDR_UNIT2_VALUE_LOW:  AVS_READDATA_O <= {24'h0, value2[7:0]};
                    `ADDR_UNIT2_VALUE_HIGH: AVS_READDATA_O <= {24'h0, value2[15:8]};
                    `ADDR_TIME_BASE:        AVS_READDATA_O <= {30'h0, time_base_select};
                    `ADDR_FLAGS:            AVS_READDATA_O <= {30'h0, flag2, flag1};
                    default:                AVS_READDATA_O <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// [design/capture_compare_defs.vh]
`ifndef CAPTURE_COMPARE_DEFS_VH
`define CAPTURE_COMPARE_DEFS_VH

// ----------------------------------------
// register word addresses (byte address = 4 * index)
// ----------------------------------------
`define ADDR_UNIT1_CONTROL    4'h0
`define ADDR_UNIT1_VALUE_LOW  4'h1
`define ADDR_UNIT1_VALUE_HIGH 4'h2
`define ADDR_UNIT2_CONTROL    4'h3
`define ADDR_UNIT2_VALUE_LOW  4'h4
`define ADDR_UNIT2_VALUE_HIGH 4'h5
`define ADDR_TIME_BASE        4'h6
`define ADDR_FLAGS            4'h7

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define CTRL_WRITE_MASK       8'h3f
`define CTRL_RESET            8'h00
`define VALUE_RESET           16'h0000
`define SEL_RESET             2'h0

// ----------------------------------------
// mode codes
// ----------------------------------------
`define MODE_OFF              4'h0
`define MODE_CMP_TOGGLE       4'h2
`define MODE_CAP_FALL         4'h4
`define MODE_CAP_RISE         4'h5
`define MODE_CAP_RISE4        4'h6
`define MODE_CAP_RISE16       4'h7
`define MODE_CMP_SET_HIGH     4'h8
`define MODE_CMP_SET_LOW      4'h9
`define MODE_CMP_SOFT         4'ha
`define MODE_CMP_SPECIAL      4'hb

`endif

// [bench/capture_compare_properties.sv]
`timescale 1ns/10ps
module capture_compare_properties (
    // clock, reset and bus
    input wire        CORE_CLK_I,
    input wire        RST_I,
    input wire [3:0]  AVS_ADDRESS_I,
    input wire        AVS_READ_I,
    input wire        AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0]  AVS_BYTEENABLE_I,
    input wire [31:0] AVS_READDATA_O,
    input wire        AVS_WAITREQUEST_O,
    // timers, converter, unit1 pin and flag
    input wire        FIRST_TIMER_CLEAR_O,
    input wire        THIRD_TIMER_CLEAR_O,
    input wire        CONVERTER_ENABLED_I,
    input wire        CONVERSION_START_O,
    input wire        UNIT1_PIN_O,
    input wire        UNIT1_PIN_OWNED_O,
    input wire        UNIT1_EVENT_FLAG_O
);
    // ----------------------------------------
    // shadow of mode and select fields
    // ----------------------------------------
    reg [3:0] m1;
    reg [3:0] m2;
    reg [1:0] sel;
    wire      wr       = AVS_WRITE_I && AVS_BYTEENABLE_I[0];
    wire      m1_quiet = (m1 == 4'h0) || (m1 == 4'h1) || (m1 == 4'h3) || (m1[3:2] == 2'b11);
    wire      m1_owns  = (m1 == 4'h2) || (m1 == 4'h8) || (m1 == 4'h9);
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            m1 <= 4'h0;
            m2 <= 4'h0;
            sel <= 2'h0;
        end else if (wr) begin
            if (AVS_ADDRESS_I == 4'h0) m1 <= AVS_WRITEDATA_I[3:0];
            if (AVS_ADDRESS_I == 4'h3) m2 <= AVS_WRITEDATA_I[3:0];
            if (AVS_ADDRESS_I == 4'h6) sel <= AVS_WRITEDATA_I[1:0];
        end
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    ctrl_top_zero_a: assert property (
        AVS_READ_I && !AVS_WAITREQUEST_O && (AVS_ADDRESS_I == 4'h0 || AVS_ADDRESS_I == 4'h3)
        |-> AVS_READDATA_O[31:6] == 26'h0) else $error("control upper bits not zero");
    write_no_wait_a: assert property (
        AVS_WRITE_I |-> !AVS_WAITREQUEST_O) else $error("write stalled");
    read_wait_one_a: assert property (
        AVS_READ_I && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O) else $error("read wait too long");
    flag_sticky_a: assert property (
        $fell(UNIT1_EVENT_FLAG_O) |-> $past(wr && AVS_ADDRESS_I == 4'h7 && AVS_WRITEDATA_I[0]))
        else $error("flag cleared without software");
    quiet_no_flag_a: assert property (
        m1_quiet && !UNIT1_EVENT_FLAG_O |=> !UNIT1_EVENT_FLAG_O) else $error("flag set in idle mode");
    pin_owner_a: assert property (
        UNIT1_PIN_OWNED_O == m1_owns) else $error("pin ownership wrong");
    latch_entry_a: assert property (
        wr && AVS_ADDRESS_I == 4'h0 && (AVS_WRITEDATA_I[3:0] == 4'h0 || AVS_WRITEDATA_I[3:1] == 3'b100)
        |=> UNIT1_PIN_O == $past(AVS_WRITEDATA_I[0])) else $error("latch not initialised");
    first_clear_a: assert property (
        FIRST_TIMER_CLEAR_O |-> (m1 == 4'hb && !sel[1]) || (m2 == 4'hb && sel == 2'b00))
        else $error("first timer cleared wrongly");
    third_clear_a: assert property (
        THIRD_TIMER_CLEAR_O |-> (m1 == 4'hb && sel[1]) || (m2 == 4'hb && sel != 2'b00))
        else $error("third timer cleared wrongly");
    convert_start_a: assert property (
        CONVERSION_START_O |-> CONVERTER_ENABLED_I && m2 == 4'hb) else $error("stray conversion start");
endmodule

// [bench/pin_source.sv]
`timescale 1ns/10ps
module pin_source (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // request
    input  wire       go_i,
    input  wire [4:0] edges_i,
    // pin side
    output reg        pin_o,
    output wire       busy_o
);
    reg [4:0] left;
    reg [2:0] phase;
    assign busy_o = (left != 5'h0);
    // pin only driven from outside
    // pulses 4 high, 4 low; pin rests low between bursts
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_o <= 1'b0;
            left <= 5'h0;
            phase <= 3'h0;
        end else if (left == 5'h0) begin
            phase <= 3'h0;
            if (go_i) left <= edges_i;
        end else begin
            phase <= phase + 3'h1;
            if (phase == 3'h3) pin_o <= 1'b1;
            if (phase == 3'h7) pin_o <= 1'b0;
            if (phase == 3'h7) left <= left - 5'h1;
        end
    end
endmodule

// [bench/testbench.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t %h %h", $time, g, e); end end
module testbench;
    reg         clk, rst, rd, wr, run, go;
    reg  [3:0]  addr;
    reg  [4:0]  edges;
    reg  [31:0] wdata, q;
    reg  [15:0] t1, t3;
    wire [31:0] rdata;
    wire        wait_req, clr1, clr3, conv, pin_in, busy;
    wire [1:0]  pin, own, flag;
    integer     miscompares, checks_done, cycles, nclr, nconv;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    capture_compare_unit u_dut (.CORE_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'h1), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wait_req), .FIRST_TIMER_I(t1), .THIRD_TIMER_I(t3), .FIRST_TIMER_CLEAR_O(clr1),
        .THIRD_TIMER_CLEAR_O(clr3), .CONVERTER_ENABLED_I(1'b1), .CONVERSION_START_O(conv),
        .UNIT1_PIN_I(pin_in), .UNIT2_PIN_I(pin_in), .UNIT1_PIN_O(pin[0]), .UNIT2_PIN_O(pin[1]),
        .UNIT1_PIN_OWNED_O(own[0]), .UNIT2_PIN_OWNED_O(own[1]), .UNIT1_EVENT_FLAG_O(flag[0]),
        .UNIT2_EVENT_FLAG_O(flag[1]));
    pin_source u_pin (.clk_i(clk), .rst_i(rst), .go_i(go), .edges_i(edges), .pin_o(pin_in), .busy_o(busy));
    // timers advance on the core clock only
    always @(posedge clk) begin
        cycles++;
        if (run) t1 <= clr1 ? 16'h0 : t1 + 16'h1;
        if (run) t3 <= clr3 ? 16'h0 : t3 + 16'h1;
        if (clr1 === 1'b1 || clr3 === 1'b1) nclr++;
        if (conv === 1'b1) nconv++;
        if (cycles > 20000) begin
            miscompares++;
            stop_test;
        end
    end
    task stop_test;
        $display("checks %0d bad %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one bus cycle; waits for waitrequest low, only the cycle ceiling ends a hang
    task bus(input r, input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            rd <= r;
            wr <= !r;
            addr <= a;
            wdata <= {24'h0, d};
            do @(posedge clk); while (wait_req !== 1'b0);
            q = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task pulses(input [4:0] k);
        integer n;
        begin
            @(posedge clk);
            go <= 1'b1;
            edges <= k;
            @(posedge clk);
            go <= 1'b0;
            @(posedge clk);
            n = 0;
            while (busy !== 1'b0 && n < 400) begin @(posedge clk); n++; end
            // sync plus capture takes three edges
            repeat (4) @(posedge clk);
        end
    endtask
    task regs;
        integer a;
        begin
            for (a = 0; a < 9; a++) begin bus(1, a[3:0], 0); `CHK(q, 32'h0) end
            bus(0, 4'h0, 8'hff);
            bus(1, 4'h0, 0); `CHK(q, 32'h3f)
            for (a = 1; a < 6; a++) if (a != 3) bus(0, a[3:0], {a[3:0], ~a[3:0]});
            for (a = 1; a < 6; a++) if (a != 3) begin bus(1, a[3:0], 0); `CHK(q, {24'h0, a[3:0], ~a[3:0]}) end
            bus(0, 4'h9, 8'hff);
            bus(1, 4'h9, 0); `CHK(q, 32'h0)
            bus(0, 4'h0, 8'h0);
            $display("regs done");
        end
    endtask
    task cap(input [3:0] m, input [4:0] k);
        begin
            bus(0, 4'h0, 8'h0);
            t1 <= {m, 12'h5a3};
            bus(0, 4'h0, {4'h0, m});
            // drop any spurious flag after mode change
            bus(0, 4'h7, 8'h3);
            if (k > 1) begin pulses(k - 5'h1); `CHK(flag[0], 1'b0) end
            pulses(1); `CHK(flag[0], 1'b1)
            bus(1, 4'h1, 0); `CHK(q[7:0], 8'ha3)
            bus(1, 4'h2, 0); `CHK(q[7:0], {m, 4'h5})
            bus(0, 4'h7, 8'h1);
            @(negedge clk); `CHK(flag[0], 1'b0)
            $display("capture %h done", m);
        end
    endtask
    // direct prescale switch keeps the count, so the capture comes early
    task presc_keep;
        begin
            bus(0, 4'h0, 8'h0);
            bus(0, 4'h0, 8'h6);
            pulses(2);
            bus(0, 4'h0, 8'h7);
            bus(0, 4'h7, 8'h3);
            pulses(14); `CHK(flag[0], 1'b1)
            bus(0, 4'h0, 8'h0);
            $display("prescale switch done");
        end
    endtask
    task sel_cap;
        integer s;
        begin
            @(posedge clk);
            t1 <= 16'h1111;
            t3 <= 16'h2222;
            for (s = 0; s < 3; s++) begin
                bus(0, 4'h6, s[7:0]);
                bus(0, 4'h0, 8'h5);
                bus(0, 4'h3, 8'h5);
                pulses(1);
                bus(1, 4'h2, 0); `CHK(q[7:0], s[1] ? 8'h22 : 8'h11)
                bus(1, 4'h5, 0); `CHK(q[7:0], s == 0 ? 8'h11 : 8'h22)
            end
            $display("select done");
        end
    endtask
    task cmp(input u, input [3:0] m, input [1:0] s, input e);
        begin
            @(posedge clk);
            t1 <= 16'h0;
            t3 <= 16'h0;
            bus(0, 4'h6, {6'h0, s});
            bus(0, 4'h0, 8'h0);
            bus(0, 4'h3, 8'h0);
            bus(0, u ? 4'h4 : 4'h1, 8'h20);
            bus(0, u ? 4'h5 : 4'h2, 8'h0);
            bus(0, 4'h7, 8'h3);
            bus(0, u ? 4'h3 : 4'h0, {4'h0, m});
            nclr = 0;
            nconv = 0;
            run <= 1'b1;
            repeat (48) @(posedge clk);
            run <= 1'b0;
            @(negedge clk); `CHK(flag[u], 1'b1)
            `CHK(pin[u], e)
            `CHK(nclr, (m == 4'hb) ? 1 : 0)
            `CHK(nconv, (m == 4'hb && u) ? 1 : 0)
            `CHK(own[u], (m == 4'h2 || m[3:1] == 3'b100))
            $display("compare %h done", m);
        end
    endtask
    initial begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; run = 1'b0; go = 1'b0;
        addr = 4'h0; edges = 5'h0; wdata = 32'h0; t1 = 16'h0; t3 = 16'h0;
        miscompares = 0; checks_done = 0; cycles = 0; nclr = 0; nconv = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        regs;
        cap(4'h4, 5'd1);
        cap(4'h5, 5'd1);
        cap(4'h6, 5'd4);
        cap(4'h7, 5'd16);
        presc_keep;
        sel_cap;
        cmp(1'b0, 4'h2, 2'h0, 1'b1);
        cmp(1'b0, 4'h8, 2'h0, 1'b1);
        cmp(1'b0, 4'h9, 2'h0, 1'b0);
        cmp(1'b0, 4'ha, 2'h0, 1'b0);
        cmp(1'b0, 4'hb, 2'h2, 1'b0);
        cmp(1'b1, 4'hb, 2'h0, 1'b0);
        stop_test;
    end
endmodule
bind capture_compare_unit capture_compare_properties u_props (.*);
